// ===== design/swc_pkg.sv
package swc_pkg;
   // =====================================================
   // Register map (word aligned byte offsets)
   localparam logic [7:0] SWC_OFF_CTRL   = 8'h00;
   localparam logic [7:0] SWC_OFF_STATUS = 8'h04;
   localparam logic [7:0] SWC_OFF_IRQEN  = 8'h08;
   localparam logic [7:0] SWC_OFF_EVT    = 8'h0C;
   localparam logic [7:0] SWC_OFF_MASK   = 8'h10;
   localparam logic [7:0] SWC_OFF_PORT   = 8'h14;
   // Control fields
   localparam int SWC_CTRL_GIE    = 0;
   localparam int SWC_CTRL_WDTEN  = 1;
   localparam int SWC_CTRL_RCMODE = 2;
   // Status fields
   localparam int SWC_ST_PD     = 0;
   localparam int SWC_ST_TO     = 1;
   localparam int SWC_ST_ASLEEP = 2;
   // Event fields
   localparam int SWC_EV_ENTER  = 0;
   localparam int SWC_EV_NOP    = 1;
   localparam int SWC_EV_WAKE   = 2;
   localparam int SWC_EV_WDT    = 3;
   localparam int SWC_EV_W      = 4;
   // Wake source index: 0 ext pin, 1 port b change, 2..9 peripherals
   localparam int SWC_NSRC      = 10;
   localparam int SWC_PC_W      = 13;
   localparam logic [12:0] SWC_IRQ_VECTOR = 13'h0004;
   localparam int SWC_PC_STEP   = 1;
   localparam int SWC_CLKDIV    = 4;
   // Reset values
   localparam logic [2:0] SWC_CTRL_RST   = 3'h2;
   localparam logic [9:0] SWC_IRQEN_RST  = 10'h000;
   localparam int SWC_WDT_W     = 16;
endpackage

// ===== design/swc_sleep_wakeup_control.sv
module swc_sleep_wakeup_control
   import swc_pkg::*;
#(
   parameter int WDT_LIMIT = 1000
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_sys_rst,
   input  wire logic                  i_master_clear_pin_n,
   input  wire logic                  i_sleep_exec,
   input  wire logic                  i_wdt_clear,
   input  wire logic [SWC_PC_W-1:0]   i_pc,
   input  wire logic [SWC_NSRC-1:0]   i_irq_flag,
   input  wire logic [SWC_NSRC-1:0]   i_async_ok,
   input  wire logic [7:0]            i_port_out,
   input  wire logic [7:0]            i_port_oe,
   input  wire logic [31:0]           i_wb_adr,
   input  wire logic [31:0]           i_wb_dat,
   input  wire logic                  i_wb_we,
   input  wire logic [3:0]            i_wb_sel,
   input  wire logic                  i_wb_cyc,
   input  wire logic                  i_wb_stb,
   output logic      [31:0]           o_wb_dat,
   output logic                       o_wb_ack,
   output logic                       o_osc_en,
   output logic                       o_osc_out,
   output logic                       o_core_rst,
   output logic                       o_resume,
   output logic                       o_vector_go,
   output logic      [SWC_PC_W-1:0]   o_fetch_addr,
   output logic      [7:0]            o_port_out,
   output logic      [7:0]            o_port_oe,
   output logic                       o_irq
);
   initial begin
      if (WDT_LIMIT < 2 || WDT_LIMIT > 65535) $error("WDT_LIMIT out of range");
   end

   typedef enum logic [1:0] {SWC_RUN, SWC_SLEEP, SWC_POST} swc_state_t;

   // =====================================================
   // Pin synchronisers
   logic master_clear_pin_s1_ff, master_clear_pin_s2_ff;
   logic [SWC_NSRC-1:0] irq_s1_ff, irq_s2_ff, aok_s1_ff, aok_s2_ff;
   always_ff @(posedge i_clk) begin
      master_clear_pin_s1_ff <= i_master_clear_pin_n;
      master_clear_pin_s2_ff <= master_clear_pin_s1_ff;
      irq_s1_ff  <= i_irq_flag;
      irq_s2_ff  <= irq_s1_ff;
      aok_s1_ff  <= i_async_ok;
      aok_s2_ff  <= aok_s1_ff;
   end

   // =====================================================
   // Registers and state
   swc_state_t state_ff, nxt_state;
   logic [2:0]            ctrl_ff;
   logic [SWC_NSRC-1:0]   irqen_ff;
   logic [SWC_EV_W-1:0]   evt_ff, mask_ff;
   logic                  pd_ff, to_ff;
   logic [SWC_WDT_W-1:0]  wdt_ff;
   logic [1:0]            div_ff;
   logic [SWC_PC_W-1:0]   fetch_ff;
   logic [7:0]            port_out_ff, port_oe_ff;
   logic                  ack_ff;
   logic                  osc_en_ff;
   logic                  osc_out_ff;
   logic                  rst_ff;
   logic                  resume_ff;
   logic                  vec_ff;
   logic                  irq_ff;
   logic                  wake_irq_ff;
   logic [31:0]           rdat_ff;

   // Only sources allowed in sleep may count while asleep
   wire logic asleep     = (state_ff == SWC_SLEEP);
   wire logic [SWC_NSRC-1:0] live_irq = irq_s2_ff & (asleep ? aok_s2_ff : '1);
   wire logic irq_pend   = |(live_irq & irqen_ff);
   wire logic master_clear_pin_evt   = ~master_clear_pin_s2_ff;
   wire logic wdt_to     = ctrl_ff[SWC_CTRL_WDTEN] && (wdt_ff == SWC_WDT_W'(WDT_LIMIT - 1));
   wire logic sleep_go   = (state_ff == SWC_RUN) && i_sleep_exec && !irq_pend && !master_clear_pin_evt;
   wire logic sleep_nop  = (state_ff == SWC_RUN) && i_sleep_exec && irq_pend;
   wire logic wake_wdt   = asleep && wdt_to;
   wire logic wake_irq   = asleep && irq_pend;
   wire logic wake_any   = wake_wdt || wake_irq;

   // Bus decode
   wire logic bus_req    = i_wb_cyc && i_wb_stb && !ack_ff;
   // Writes land on the edge at which the master sees ack
   wire logic bus_wr     = i_wb_cyc && i_wb_stb && ack_ff && i_wb_we && i_wb_sel[0];
   wire logic bus_rd     = bus_req && !i_wb_we;
   wire logic [7:0] badr = i_wb_adr[7:0];
   wire logic evt_rd     = bus_rd && (badr == SWC_OFF_EVT);
   wire logic [SWC_EV_W-1:0] evt_set = {wake_wdt, wake_any, sleep_nop, sleep_go};

   // Read mux
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      case (badr)
         SWC_OFF_CTRL:   rmux = {29'h0, ctrl_ff};
         SWC_OFF_STATUS: rmux = {29'h0, asleep, to_ff, pd_ff};
         SWC_OFF_IRQEN:  rmux = {22'h0, irqen_ff};
         SWC_OFF_EVT:    rmux = {28'h0, evt_ff};
         SWC_OFF_MASK:   rmux = {28'h0, mask_ff};
         SWC_OFF_PORT:   rmux = {16'h0, port_oe_ff, port_out_ff};
         default:        rmux = 32'h0000_0000;
      endcase
   end

   // Sleep sequence
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SWC_RUN:   if (sleep_go) nxt_state = SWC_SLEEP;
         SWC_SLEEP: if (wake_any) nxt_state = SWC_POST;
         SWC_POST:  nxt_state = SWC_RUN;
         default:   nxt_state = SWC_RUN;
      endcase
   end

   // =====================================================
   // Master clear reset dominates the sleep state, status flags and core reset
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || master_clear_pin_evt) begin
         state_ff <= SWC_RUN;
         pd_ff    <= 1'b1;
         to_ff    <= 1'b1;
         rst_ff   <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         rst_ff   <= 1'b0;
         if (sleep_go) begin
            pd_ff <= 1'b0;
            to_ff <= 1'b1;
         end else if (wake_wdt) begin
            to_ff <= 1'b0;
         end
      end
   end

   // Watchdog keeps running through sleep; sleep clears it
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || master_clear_pin_evt || sleep_go || i_wdt_clear || wdt_to)
         wdt_ff <= '0;
      else if (ctrl_ff[SWC_CTRL_WDTEN])
         wdt_ff <= wdt_ff + SWC_WDT_W'(1);
   end

   // Oscillator, divider, resume handshake
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         osc_en_ff  <= 1'b1;
         div_ff     <= 2'h0;
         osc_out_ff <= 1'b0;
         resume_ff  <= 1'b0;
         vec_ff     <= 1'b0;
         fetch_ff   <= '0;
      end else begin
         if (sleep_go) osc_en_ff <= 1'b0;
         else if (wake_any || master_clear_pin_evt) osc_en_ff <= 1'b1;
         // Divider freezes with the oscillator, so the pin stops too
         if (osc_en_ff) div_ff <= div_ff + 2'h1;
         osc_out_ff <= ctrl_ff[SWC_CTRL_RCMODE] && osc_en_ff && div_ff[1];
         if (sleep_go) fetch_ff <= i_pc + SWC_PC_W'(SWC_PC_STEP);
         resume_ff <= wake_any;
         vec_ff    <= (state_ff == SWC_POST) && wake_irq_ff && ctrl_ff[SWC_CTRL_GIE];
      end
   end

   // Remember that the wake came from an interrupt
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) wake_irq_ff <= 1'b0;
      else if (wake_any) wake_irq_ff <= wake_irq;
   end

   // Port latch: frozen while asleep
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         port_out_ff <= 8'h00;
         port_oe_ff  <= 8'h00;
      end else if (!asleep) begin
         port_out_ff <= i_port_out;
         port_oe_ff  <= i_port_oe;
      end
   end

   // Bus slave and interrupt status; set wins over read clear
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ctrl_ff  <= SWC_CTRL_RST;
         irqen_ff <= SWC_IRQEN_RST;
         mask_ff  <= '0;
         evt_ff   <= '0;
         ack_ff   <= 1'b0;
         rdat_ff  <= 32'h0000_0000;
         irq_ff   <= 1'b0;
      end else begin
         ack_ff  <= bus_req;
         rdat_ff <= bus_rd ? rmux : 32'h0000_0000;
         if (bus_wr && badr == SWC_OFF_CTRL)  ctrl_ff  <= i_wb_dat[2:0];
         if (bus_wr && badr == SWC_OFF_IRQEN) irqen_ff <= i_wb_dat[SWC_NSRC-1:0];
         if (bus_wr && badr == SWC_OFF_MASK)  mask_ff  <= i_wb_dat[SWC_EV_W-1:0];
         evt_ff <= (evt_rd ? '0 : evt_ff) | evt_set;
         irq_ff <= |(((evt_rd ? '0 : evt_ff) | evt_set) & mask_ff);
      end
   end

   assign o_wb_dat     = rdat_ff;
   assign o_wb_ack     = ack_ff;
   assign o_osc_en     = osc_en_ff;
   assign o_osc_out    = osc_out_ff;
   assign o_core_rst   = rst_ff;
   assign o_resume     = resume_ff;
   assign o_vector_go  = vec_ff;
   assign o_fetch_addr = fetch_ff;
   assign o_port_out   = port_out_ff;
   assign o_port_oe    = port_oe_ff;
   assign o_irq        = irq_ff;

   // =====================================================
   // Checks
   chk_sleep_flags: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      sleep_go && !master_clear_pin_evt |=> !pd_ff && !osc_en_ff && wdt_ff == '0) else $error("sleep entry flags wrong");
   chk_nop_keeps: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      sleep_nop && !master_clear_pin_evt |=> $stable(pd_ff) && state_ff == SWC_RUN) else $error("nop sleep altered state");
   chk_port_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      asleep |=> $stable(o_port_out) && $stable(o_port_oe)) else $error("port moved in sleep");
   chk_wdt_to: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wake_wdt && !master_clear_pin_evt |=> !to_ff) else $error("timeout flag not cleared");
   chk_irq_wake: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wake_irq && !master_clear_pin_evt |=> o_resume ##1 state_ff == SWC_RUN) else $error("irq wake missing");
   chk_master_clear_pin_rst: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      master_clear_pin_evt |=> o_core_rst && pd_ff) else $error("master clear no reset");
   chk_prefetch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      sleep_go |=> o_fetch_addr == $past(i_pc) + SWC_PC_W'(1)) else $error("prefetch address wrong");
   chk_vector: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wake_irq && ctrl_ff[SWC_CTRL_GIE] && !master_clear_pin_evt |=> ##1 o_vector_go) else $error("vector not taken");

   // Resume is a single-cycle pulse
   chk_resume_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_resume |=> !o_resume) else $error("resume pulse too long");

   // No vector branch with global enable clear
   chk_vec_gie_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wake_irq && !ctrl_ff[SWC_CTRL_GIE] ##1 !ctrl_ff[SWC_CTRL_GIE] |=> !o_vector_go) else $error("vector without enable");

   // Vector only after the next instruction has resumed
   chk_vec_after_res: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_vector_go |-> $past(o_resume)) else $error("vector before resume");

   // Any wake restarts the oscillator
   chk_osc_wake: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wake_any |=> o_osc_en) else $error("oscillator not restarted");

   // Oscillator stays off while sleeping undisturbed
   chk_osc_sleep_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      asleep && !wake_any && !master_clear_pin_evt |=> !o_osc_en) else $error("oscillator on in sleep");

   // Sleep entry sets the timeout flag
   chk_to_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      sleep_go |=> to_ff) else $error("timeout flag not set");

   // Interrupt wake keeps the completed sleep visible
   chk_wake_pd_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wake_irq && !master_clear_pin_evt |=> !pd_ff) else $error("power-down flag lost");

   // Skipped sleep leaves the watchdog counting
   chk_nop_wdt_runs: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      sleep_nop && ctrl_ff[SWC_CTRL_WDTEN] && !i_wdt_clear && !wdt_to && !master_clear_pin_evt
      |=> wdt_ff == $past(wdt_ff) + SWC_WDT_W'(1)) else $error("watchdog cleared by nop");

   // Skipped sleep leaves the timeout flag alone
   chk_nop_to_kept: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      sleep_nop && !master_clear_pin_evt |=> $stable(to_ff)) else $error("timeout flag changed by nop");

   // Disabled sources never wake
   chk_no_en_stays: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      asleep && !(|(irq_s2_ff & irqen_ff)) && !wdt_to && !master_clear_pin_evt |=> asleep) else $error("woke without enable");

   // Phase-clocked sources stay silent in sleep
   chk_phase_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      asleep && !(|(irq_s2_ff & aok_s2_ff & irqen_ff)) && !wdt_to && !master_clear_pin_evt |=> asleep)
      else $error("clocked source woke device");

   // Enabled async source wakes whatever the global enable
   chk_gie_free: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      asleep && |(irq_s2_ff & aok_s2_ff & irqen_ff) && !master_clear_pin_evt |=> state_ff == SWC_POST)
      else $error("enabled source did not wake");

   // Post-wake state lasts one cycle
   chk_post_once: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state_ff == SWC_POST |=> state_ff == SWC_RUN) else $error("post state stuck");

   // Prefetch address only moves on sleep entry
   chk_fetch_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !sleep_go |=> $stable(o_fetch_addr)) else $error("prefetch moved");

   // Core reset only from reset or master clear
   chk_core_rst_src: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_core_rst |-> $past(i_sys_rst || master_clear_pin_evt)) else $error("spurious core reset");

   // Other wakes resume without reset
   chk_no_rst_wake: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wake_any && !master_clear_pin_evt |=> !o_core_rst) else $error("wake caused reset");

   // Clock-out high for two cycles at most
   chk_div_pattern: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_osc_out && $past(o_osc_out) |=> !o_osc_out) else $error("clock-out not divided");

   // Clock-out only in RC mode with oscillator on
   chk_div_mode: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_osc_out |-> $past(ctrl_ff[SWC_CTRL_RCMODE] && osc_en_ff)) else $error("clock-out outside mode");

   // Ack lasts exactly one cycle
   chk_ack_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_wb_ack |=> !o_wb_ack) else $error("ack held too long");

   // Wake event is recorded
   chk_evt_wake: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wake_any |=> evt_ff[SWC_EV_WAKE]) else $error("wake event lost");

   // Ports follow the core while awake
   chk_port_follow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !asleep |=> o_port_out == $past(i_port_out)) else $error("port not following");

   // Reset always leaves the power-down flag set
   chk_pd_power: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_core_rst |-> pd_ff) else $error("power-down flag not set");

   // Sleep entry is recorded
   chk_evt_enter: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      sleep_go |=> evt_ff[SWC_EV_ENTER]) else $error("entry event lost");

   // Skipped sleep is recorded
   chk_evt_nop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      sleep_nop |=> evt_ff[SWC_EV_NOP]) else $error("nop event lost");

   // Watchdog wake is recorded
   chk_evt_wdt: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wake_wdt |=> evt_ff[SWC_EV_WDT]) else $error("watchdog event lost");

   // Fully masked events never interrupt
   chk_irq_masked: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $past(mask_ff) == '0 |-> !o_irq) else $error("masked interrupt raised");

   // Sleeping implies power-down flag clear
   chk_asleep_pd: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      asleep |-> !pd_ff) else $error("asleep with flag set");

   // Real sleep enters the sleep state
   chk_sleep_state: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      sleep_go |=> asleep) else $error("sleep not entered");

   // Master clear always returns to run
   chk_master_clear_pin_run: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      master_clear_pin_evt |=> state_ff == SWC_RUN) else $error("master clear left sleep");

   // Watchdog keeps counting in sleep
   chk_wdt_sleep_runs: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      asleep && ctrl_ff[SWC_CTRL_WDTEN] && !wdt_to && !master_clear_pin_evt && !i_wdt_clear
      |=> wdt_ff == $past(wdt_ff) + SWC_WDT_W'(1)) else $error("watchdog stopped in sleep");

   // Read data is zero outside the ack cycle
   chk_rdat_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !o_wb_ack |-> o_wb_dat == 32'h0000_0000) else $error("read data leaked");
endmodule

// ===== sim/swc_far_side.sv
module swc_far_side;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Reset pin and interrupt sources, driven after the clock edge
   logic       clk = 1'b0;
   logic       master_clear_pin_n = 1'b1;
   logic [9:0] flags = 10'h000;
   logic [9:0] async_ok = 10'h3FF;
   // Hold master clear low long enough to pass the synchroniser
   task automatic hold_master_clear_pin(input int n);
      @(posedge clk) master_clear_pin_n <= 1'b0;
      repeat (n) @(posedge clk);
      master_clear_pin_n <= 1'b1;
   endtask
   // Async mask says which sources still run without phase clocks
   task automatic set_src(input logic [9:0] f, input logic [9:0] a);
      @(posedge clk);
      flags <= f;
      async_ok <= a;
   endtask
endmodule

// ===== sim/swc_sleep_wakeup_control_tb.sv
module swc_sleep_wakeup_control_tb;
   import swc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Stimulus and design
   logic clk = 0, rst = 1, slp = 0, wclr = 0, cyc = 0, stb = 0, we = 0;
   logic [12:0] pc = 13'h0000;
   logic [7:0]  pout = 8'hA5, poe = 8'h0F;
   logic [31:0] adr = 0, dat = 0, rd, q;
   logic [3:0]  sel = 4'h0;
   logic [31:0] w_dat;
   logic        w_ack, osc_en, osc_out, core_rst, resume, vgo, irq, a0, a1;
   logic [12:0] fetch;
   logic [7:0]  p_o, p_e;
   int          n_fail = 0, total_checks = 0, k, cnt;
   always #20 clk = ~clk;
   always @(clk) u_far.clk = clk;
   swc_far_side u_far ();
   swc_sleep_wakeup_control #(.WDT_LIMIT(20)) u_dut (.i_clk(clk), .i_sys_rst(rst), .i_master_clear_pin_n(u_far.master_clear_pin_n),
      .i_sleep_exec(slp), .i_wdt_clear(wclr), .i_pc(pc), .i_irq_flag(u_far.flags), .i_async_ok(u_far.async_ok),
      .i_port_out(pout), .i_port_oe(poe), .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_we(we), .i_wb_sel(sel),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(w_dat), .o_wb_ack(w_ack), .o_osc_en(osc_en),
      .o_osc_out(osc_out), .o_core_rst(core_rst), .o_resume(resume), .o_vector_go(vgo),
      .o_fetch_addr(fetch), .o_port_out(p_o), .o_port_oe(p_e), .o_irq(irq));
   // ==========
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Classic cycle: hold request until ack is sampled, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      cyc <= 1; stb <= 1; we <= w; adr <= {24'h0, a}; dat <= d; sel <= 4'hF;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (w_ack !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_fail++;
         print_verdict;
      end
      r = w_dat;
      cyc <= 0; stb <= 0; we <= 0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      wb(0, a, 0, rd);
      chk(rd, e);
   endtask
   // Clear the watchdog first so the sleep starts from a known count
   task automatic do_sleep(input logic [12:0] p);
      @(posedge clk) wclr <= 1;
      @(posedge clk) begin wclr <= 0; slp <= 1; pc <= p; end
      @(posedge clk) slp <= 0;
      repeat (2) @(posedge clk);
   endtask
   // Bounded wait for the one-cycle resume pulse
   task automatic wait_resume(input int lim);
      k = 0;
      while (resume !== 1'b1 && k < lim) begin @(posedge clk); k++; end
      chk({31'h0, resume}, 1);
      if (resume !== 1'b1) print_verdict;
   endtask
   task automatic print_verdict;
      $display("checks=%0d fails=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      print_verdict;
   end
   // ==========
   // Scenarios
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      repeat (3) @(posedge clk);
      rchk(SWC_OFF_CTRL, 32'h2);
      rchk(SWC_OFF_STATUS, 32'h3);
      rchk(8'h20, 32'h0);
      wb(1, SWC_OFF_IRQEN, 32'h5, q);
      wb(1, SWC_OFF_CTRL, 32'h0, q);
      do_sleep(13'h0100);
      rchk(SWC_OFF_STATUS, 32'h6);
      chk({31'h0, osc_en}, 0);
      chk({19'h0, fetch}, 32'h101);
      @(posedge clk) pout <= 8'h3C;
      poe <= 8'hF0;
      repeat (3) @(posedge clk);
      chk({16'h0, p_o, p_e}, 32'hA50F);
      u_far.set_src(10'h002, 10'h3FF);
      repeat (30) @(posedge clk);
      rchk(SWC_OFF_STATUS, 32'h6);
      u_far.set_src(10'h004, 10'h003);
      repeat (30) @(posedge clk);
      rchk(SWC_OFF_STATUS, 32'h6);
      u_far.set_src(10'h004, 10'h3FF);
      wait_resume(20);
      @(posedge clk) chk({31'h0, vgo}, 0);
      chk({31'h0, osc_en}, 1);
      chk({31'h0, core_rst}, 0);
      u_far.set_src(10'h000, 10'h3FF);
      cnt = 0;
      fork
         u_far.hold_master_clear_pin(6);
         repeat (8) @(posedge clk) if (core_rst === 1'b1) cnt++;
      join
      chk({31'h0, cnt > 0}, 1);
      repeat (4) @(posedge clk);
      rchk(SWC_OFF_STATUS, 32'h3);
      wb(1, SWC_OFF_CTRL, 32'h0, q);
      wb(1, SWC_OFF_IRQEN, 32'h1, q);
      u_far.set_src(10'h001, 10'h3FF);
      repeat (3) @(posedge clk);
      do_sleep(13'h0200);
      rchk(SWC_OFF_STATUS, 32'h3);
      u_far.set_src(10'h000, 10'h3FF);
      wb(1, SWC_OFF_CTRL, 32'h1, q);
      do_sleep(13'h0300);
      u_far.set_src(10'h001, 10'h3FF);
      wait_resume(20);
      @(posedge clk) chk({31'h0, vgo}, 1);
      rchk(SWC_OFF_STATUS, 32'h2);
      u_far.set_src(10'h000, 10'h3FF);
      wb(1, SWC_OFF_CTRL, 32'h2, q);
      do_sleep(13'h0400);
      wait_resume(100);
      repeat (2) @(posedge clk);
      rchk(SWC_OFF_STATUS, 32'h0);
      wb(1, SWC_OFF_MASK, 32'h1F, q);
      @(posedge clk) a1 = irq;
      wb(1, SWC_OFF_MASK, 32'h0, q);
      @(posedge clk) a0 = irq;
      chk({31'h0, a1}, 1);
      chk({31'h0, a0}, 0);
      wb(0, SWC_OFF_EVT, 0, rd);
      chk({31'h0, rd[SWC_EV_WDT]}, 1);
      rchk(SWC_OFF_EVT, 32'h0);
      wb(1, SWC_OFF_CTRL, 32'h4, q);
      cnt = 0;
      repeat (8) @(posedge clk) if (osc_out === 1'b1) cnt++;
      chk(cnt, 4);
      print_verdict;
   end
endmodule
